//--- tcc_timer.sv
// Contract
// - counter seen as two byte locations; upper location reaches shared latch
// - low read loads latch with upper byte; low write loads upper from latch
// - low write updates all sixteen bits in one cycle
// - one shared high-byte latch for every sixteen-bit register
// - clock select field picks timer tick; zero stops counter
// - on each tick clear, increment or decrement; flag top and bottom
// - counter readable and writable with or without timer tick
// - processor write beats clear or count in the same cycle
// - waveform mode field sets count sequence and overflow condition
// - overflow flag can raise interrupt request
// - qualified capture edge copies full counter into capture value
// - capture flag set with copy; enabled flag raises interrupt
// - capture flag clears on service or by writing one
// - capture low read loads latch; upper read returns latch
// - capture writable only in capture-top modes, upper byte first
// - trigger from capture pin, or comparator when select bit set
// - changing source may capture; software clears flag afterwards
// - capture inputs synchronised and edge detected like external clock
// - capture events blocked in capture-top modes; filter and edge detector keep running in every mode
// - filter output changes after four equal consecutive samples
// - filter adds four system clock cycles of delay
// - filter enable bit in control register b
// - filter samples on undivided system clock
`timescale 1ns/1ns
`default_nettype none
module tcc_timer
    import tcc_pkg::*;
#(
    parameter int CW = 16
) (
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [11:0]   paddr,
    input  wire logic [31:0]   pwdata,
    output logic      [31:0]   prdata,
    output logic               pready,
    output logic               pslverr,
    input  wire logic          capture_pin,
    input  wire logic          comparator_output,
    input  wire logic          external_clock_pin,
    input  wire logic          prescale_tick,
    input  wire logic          capture_irq_ack,
    input  wire logic          overflow_irq_ack,
    output logic               capture_irq,
    output logic               overflow_irq,
    output logic               at_max,
    output logic               at_bottom
);
    logic [CW-1:0] count_value_q;
    logic [CW-1:0] capture_value_q;
    logic [7:0]    latch_q;
    logic [7:0]    control_reg_a_q;
    logic [7:0]    control_reg_b_q;
    logic [7:0]    comparator_control_status_q;
    logic [1:0]    irq_en_q;
    logic          overflow_flag_q;
    logic          capture_flag_q;
    logic [1:0]    cap_sync_q;
    logic [1:0]    cmp_sync_q;
    logic [1:0]    ext_sync_q;
    logic          ext_prev_q;
    logic [FILT_SAMPLES-2:0] filt_sh_q;
    logic          filt_out_q;
    logic          edge_prev_q;
    tcc_dir_t      dir_q;

    // bus decode
    wire access   = psel && penable;
    wire wr       = access && pwrite;
    wire rd       = access && !pwrite;
    wire wr_cnt_lo = wr && paddr == ADDR_CNT_LO;
    wire wr_cnt_hi = wr && paddr == ADDR_CNT_HI;
    wire wr_cap_lo = wr && paddr == ADDR_CAP_LO;
    wire wr_cap_hi = wr && paddr == ADDR_CAP_HI;
    wire rd_cnt_lo = rd && paddr == ADDR_CNT_LO;
    wire rd_cap_lo = rd && paddr == ADDR_CAP_LO;
    wire wr_ctla  = wr && paddr == ADDR_CTRL_A;
    wire wr_ctlb  = wr && paddr == ADDR_CTRL_B;
    wire wr_flags = wr && paddr == ADDR_FLAGS;
    wire wr_irqen = wr && paddr == ADDR_IRQ_EN;
    wire wr_cmp   = wr && paddr == ADDR_CMP_CTRL;
    wire mapped   = paddr == ADDR_CNT_LO || paddr == ADDR_CNT_HI ||
                    paddr == ADDR_CAP_LO || paddr == ADDR_CAP_HI ||
                    paddr == ADDR_CTRL_A || paddr == ADDR_CTRL_B ||
                    paddr == ADDR_FLAGS  || paddr == ADDR_IRQ_EN ||
                    paddr == ADDR_CMP_CTRL;
    wire [7:0] wbyte = pwdata[7:0];

    // mode fields
    wire [2:0] clock_select_field  = control_reg_b_q[CSEL_LSB +: 3];
    wire [3:0] waveform_mode_field = {control_reg_b_q[WGM_HI_LSB +: 2],
                                      control_reg_a_q[1:0]};
    wire cap_top = waveform_mode_field == WGM_CAPTOP_CTC ||
                   waveform_mode_field == WGM_CAPTOP_PWM ||
                   waveform_mode_field == WGM_CAPTOP_PFC ||
                   waveform_mode_field == WGM_CAPTOP_PC;
    wire noise_filter_enable = control_reg_b_q[NFILT_BIT];
    wire edge_rising         = control_reg_b_q[EDGE_BIT];
    wire comparator_capture_select = comparator_control_status_q[CMP_SEL_BIT];

    // external clock edges, synchronised pin
    wire ext_rise = ext_sync_q[1] && !ext_prev_q;
    wire ext_fall = !ext_sync_q[1] && ext_prev_q;
    // timer tick selection, zero stops
    wire timer_tick = (clock_select_field == CS_DIV1) ? 1'b1 :
                      (clock_select_field == CS_EXTF) ? ext_fall :
                      (clock_select_field == CS_EXTR) ? ext_rise :
                      (clock_select_field == CS_STOP) ? 1'b0 :
                      prescale_tick;

    // top selection per mode
    wire [CW-1:0] top_val = (waveform_mode_field == 4'h1 ||
                             waveform_mode_field == 4'h5) ? CW'(16'h00ff) :
                            (waveform_mode_field == 4'h2 ||
                             waveform_mode_field == 4'h6) ? CW'(16'h01ff) :
                            (waveform_mode_field == 4'h3 ||
                             waveform_mode_field == 4'h7) ? CW'(16'h03ff) :
                            cap_top ? capture_value_q : CNT_MAX;
    wire dual_slope = waveform_mode_field inside {4'h1, 4'h2, 4'h3, 4'h8,
                                                  4'h9, 4'ha, 4'hb};
    wire hit_top = count_value_q == top_val;
    wire hit_bot = count_value_q == CNT_BOT;
    wire single_clear = !dual_slope && hit_top && waveform_mode_field != 4'h0;

    // dual slope turns down at top and stays down until bottom
    wire going_down = dual_slope && (hit_top || (dir_q == TCC_DOWN && !hit_bot));
    // next count: clear, up or down
    wire [CW-1:0] cnt_step = single_clear ? CNT_BOT :
                             going_down ? count_value_q - CW'(1) :
                             count_value_q + CW'(1);
    // overflow condition per mode
    wire ovf_evt = timer_tick && (dual_slope ? (hit_bot && dir_q == TCC_DOWN)
                   : (waveform_mode_field == 4'h0 ? count_value_q == CNT_MAX
                   : hit_top));

    // capture source: each pin synchronised on its own, then selected
    wire src_sync = comparator_capture_select ? cmp_sync_q[1] : cap_sync_q[1];
    // filter window: three held samples plus the newest
    wire [FILT_SAMPLES-1:0] filt_win = {filt_sh_q, src_sync};
    wire filt_all1 = &filt_win;
    wire filt_all0 = ~|filt_win;
    wire edge_in  = noise_filter_enable ? filt_out_q : src_sync;
    wire cap_evt  = !cap_top && (edge_rising ? (edge_in && !edge_prev_q)
                    : (!edge_in && edge_prev_q));

    // flag set and clear, set wins
    wire cap_clr = (wr_flags && wbyte[CAPF_BIT]) || capture_irq_ack;
    wire ovf_clr = (wr_flags && wbyte[OVF_BIT]) || overflow_irq_ack;

    // counter register: write beats count
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            count_value_q <= CNT_RST;
        else if (wr_cnt_lo)
            count_value_q <= {latch_q, wbyte};
        else if (timer_tick)
            count_value_q <= cnt_step;
    end

    // dual slope direction
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            dir_q <= TCC_UP;
        else if (!dual_slope)
            dir_q <= TCC_UP;
        else if (timer_tick && hit_top)
            dir_q <= TCC_DOWN;
        else if (timer_tick && hit_bot)
            dir_q <= TCC_UP;
    end

    // shared high-byte latch
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            latch_q <= 8'h00;
        else if (wr_cnt_hi || wr_cap_hi)
            latch_q <= wbyte;
        else if (rd_cnt_lo)
            latch_q <= count_value_q[15:8];
        else if (rd_cap_lo)
            latch_q <= capture_value_q[15:8];
    end

    // capture register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            capture_value_q <= CNT_RST;
        else if (wr_cap_lo && cap_top)
            capture_value_q <= {latch_q, wbyte};
        else if (cap_evt)
            capture_value_q <= count_value_q;
    end

    // flags, set wins over clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            capture_flag_q  <= 1'b0;
            overflow_flag_q <= 1'b0;
        end
        else
        begin
            capture_flag_q  <= cap_evt | (capture_flag_q & ~cap_clr);
            overflow_flag_q <= ovf_evt | (overflow_flag_q & ~ovf_clr);
        end
    end

    // control registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            control_reg_a_q             <= CTRL_RST;
            control_reg_b_q             <= CTRL_RST;
            comparator_control_status_q <= CTRL_RST;
            irq_en_q                    <= 2'b00;
        end
        else
        begin
            if (wr_ctla)
                control_reg_a_q <= wbyte;
            if (wr_ctlb)
                control_reg_b_q <= wbyte;
            if (wr_cmp)
                comparator_control_status_q <= wbyte;
            if (wr_irqen)
                irq_en_q <= wbyte[1:0];
        end
    end

    // synchronisers and filter on system clock
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cap_sync_q  <= 2'b00;
            cmp_sync_q  <= 2'b00;
            ext_sync_q  <= 2'b00;
            ext_prev_q  <= 1'b0;
            filt_sh_q   <= '0;
            filt_out_q  <= 1'b0;
            edge_prev_q <= 1'b0;
        end
        else
        begin
            cap_sync_q  <= {cap_sync_q[0], capture_pin};
            cmp_sync_q  <= {cmp_sync_q[0], comparator_output};
            ext_sync_q  <= {ext_sync_q[0], external_clock_pin};
            ext_prev_q  <= ext_sync_q[1];
            filt_sh_q   <= {filt_sh_q[FILT_SAMPLES-3:0], src_sync};
            if (filt_all1)
                filt_out_q <= 1'b1;
            else if (filt_all0)
                filt_out_q <= 1'b0;
            edge_prev_q <= edge_in;
        end
    end

    // read mux, upper locations return latch
    wire [7:0] rd_byte =
        (paddr == ADDR_CNT_LO)   ? count_value_q[7:0] :
        (paddr == ADDR_CNT_HI)   ? latch_q :
        (paddr == ADDR_CAP_LO)   ? capture_value_q[7:0] :
        (paddr == ADDR_CAP_HI)   ? latch_q :
        (paddr == ADDR_CTRL_A)   ? control_reg_a_q :
        (paddr == ADDR_CTRL_B)   ? control_reg_b_q :
        (paddr == ADDR_FLAGS)    ? {6'h00, capture_flag_q, overflow_flag_q} :
        (paddr == ADDR_IRQ_EN)   ? {6'h00, irq_en_q} :
        (paddr == ADDR_CMP_CTRL) ? comparator_control_status_q : 8'h00;

    // registered bus answer, no wait state
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            prdata  <= (psel && !penable && !pwrite) ? {24'h000000, rd_byte} : prdata;
        end
    end

    // registered status outputs
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            capture_irq  <= 1'b0;
            overflow_irq <= 1'b0;
            at_max       <= 1'b0;
            at_bottom    <= 1'b1;
        end
        else
        begin
            capture_irq  <= capture_flag_q && irq_en_q[CAPF_BIT];
            overflow_irq <= overflow_flag_q && irq_en_q[OVF_BIT];
            at_max       <= hit_top;
            at_bottom    <= hit_bot;
        end
    end

    // assertions
    chk_write_prio: assert property (@(posedge pclk) disable iff (!presetn)
        wr_cnt_lo |=> count_value_q == $past({latch_q, wbyte}))
        else $error("counter write lost");
    chk_stop_hold: assert property (@(posedge pclk) disable iff (!presetn)
        (clock_select_field == CS_STOP && !wr_cnt_lo) |=> $stable(count_value_q))
        else $error("stopped counter moved");
    chk_latch_load: assert property (@(posedge pclk) disable iff (!presetn)
        rd_cnt_lo && !wr_cnt_hi && !wr_cap_hi |=> latch_q == $past(count_value_q[15:8]))
        else $error("latch not loaded");
    chk_cap_copy: assert property (@(posedge pclk) disable iff (!presetn)
        cap_evt && !(wr_cap_lo && cap_top) |=> capture_value_q == $past(count_value_q)
        && capture_flag_q)
        else $error("capture copy or flag missing");
    chk_flag_setwin: assert property (@(posedge pclk) disable iff (!presetn)
        cap_evt && cap_clr |=> capture_flag_q)
        else $error("capture lost to clear");
    chk_flag_clear: assert property (@(posedge pclk) disable iff (!presetn)
        capture_flag_q && cap_clr && !cap_evt |=> !capture_flag_q)
        else $error("capture flag not cleared");
    chk_cap_ro: assert property (@(posedge pclk) disable iff (!presetn)
        wr_cap_lo && !cap_top && !cap_evt |=> $stable(capture_value_q))
        else $error("capture written outside top mode");
    chk_filter_four: assert property (@(posedge pclk) disable iff (!presetn)
        noise_filter_enable && $changed(filt_out_q) |-> $past(filt_win) == {FILT_SAMPLES{filt_out_q}})
        else $error("filter changed without four samples");
    chk_no_cap_top: assert property (@(posedge pclk) disable iff (!presetn)
        cap_top && !wr_cap_lo |=> $stable(capture_value_q) && !$rose(capture_flag_q))
        else $error("capture in top mode");
    chk_up_count: assert property (@(posedge pclk) disable iff (!presetn)
        waveform_mode_field == 4'h0 && timer_tick && !wr_cnt_lo |=>
        count_value_q == $past(count_value_q) + CW'(1))
        else $error("normal mode step wrong");
    chk_dual_turn: assert property (@(posedge pclk) disable iff (!presetn)
        dual_slope && timer_tick && hit_top && !wr_cnt_lo |=> count_value_q == $past(count_value_q) - CW'(1))
        else $error("dual slope passed its top");
    chk_hi_write: assert property (@(posedge pclk) disable iff (!presetn)
        wr_cnt_hi && !timer_tick |=> latch_q == $past(wbyte) && $stable(count_value_q))
        else $error("upper byte write missed the latch");
    chk_cap_latch: assert property (@(posedge pclk) disable iff (!presetn)
        rd_cap_lo |=> latch_q == $past(capture_value_q[15:8]))
        else $error("capture upper byte not latched");
    chk_ovf_flag: assert property (@(posedge pclk) disable iff (!presetn)
        ovf_evt |=> overflow_flag_q)
        else $error("overflow flag not set");
    chk_ovf_irq: assert property (@(posedge pclk) disable iff (!presetn)
        overflow_flag_q && irq_en_q[OVF_BIT] |=> overflow_irq)
        else $error("overflow request missing");
    chk_cap_irq: assert property (@(posedge pclk) disable iff (!presetn)
        capture_flag_q && irq_en_q[CAPF_BIT] |=> capture_irq)
        else $error("capture request missing");
endmodule : tcc_timer
`default_nettype wire

//--- tcc_pkg.sv
package tcc_pkg;
    // register byte addresses, one aligned word each
    localparam logic [11:0] ADDR_CNT_LO   = 12'h000;
    localparam logic [11:0] ADDR_CNT_HI   = 12'h004;
    localparam logic [11:0] ADDR_CAP_LO   = 12'h008;
    localparam logic [11:0] ADDR_CAP_HI   = 12'h00c;
    localparam logic [11:0] ADDR_CTRL_A   = 12'h010;
    localparam logic [11:0] ADDR_CTRL_B   = 12'h014;
    localparam logic [11:0] ADDR_FLAGS    = 12'h018;
    localparam logic [11:0] ADDR_IRQ_EN   = 12'h01c;
    localparam logic [11:0] ADDR_CMP_CTRL = 12'h020;
    // control register b fields
    localparam int CSEL_LSB     = 0;
    localparam int WGM_HI_LSB   = 3;
    localparam int EDGE_BIT     = 6;
    localparam int NFILT_BIT    = 7;
    // flags register fields
    localparam int OVF_BIT      = 0;
    localparam int CAPF_BIT     = 1;
    // comparator control field
    localparam int CMP_SEL_BIT  = 0;
    // reset values and counter limits
    localparam logic [7:0]  CTRL_RST  = 8'h00;
    localparam logic [15:0] CNT_RST   = 16'h0000;
    localparam logic [15:0] CNT_MAX   = 16'hffff;
    localparam logic [15:0] CNT_BOT   = 16'h0000;
    // filter sample count
    localparam int FILT_SAMPLES = 4;
    // clock select codes
    localparam logic [2:0] CS_STOP = 3'h0;
    localparam logic [2:0] CS_DIV1 = 3'h1;
    localparam logic [2:0] CS_EXTF = 3'h6;
    localparam logic [2:0] CS_EXTR = 3'h7;
    // waveform modes using capture_value as top
    localparam logic [3:0] WGM_CAPTOP_CTC  = 4'hc;
    localparam logic [3:0] WGM_CAPTOP_PWM  = 4'he;
    localparam logic [3:0] WGM_CAPTOP_PFC  = 4'h8;
    localparam logic [3:0] WGM_CAPTOP_PC   = 4'ha;
    // counter direction states
    typedef enum logic [1:0] {
        TCC_UP   = 2'b01,
        TCC_DOWN = 2'b10
    } tcc_dir_t;
endpackage : tcc_pkg

//--- tcc_cpu_model.sv
`timescale 1ns/1ns
`default_nettype none
module tcc_cpu_model
    import tcc_pkg::*;
(
    input  wire logic        pclk,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [11:0]      paddr,
    output logic [31:0]      pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    // bus idle from time zero
    initial
    begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 12'h000;
        pwdata  = 32'h00000000;
    end

    // one transfer: setup cycle, then access held until pready
    task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d,
                        output logic [31:0] rdat, output logic err);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        rdat = prdata;
        err  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : xfer

    // upper byte to the latch first, then the committing lower byte, one idle cycle apart
    task automatic wr16(input logic [11:0] lo, input logic [15:0] v);
        logic [31:0] r;
        logic        e;
        xfer(1'b1, lo + 12'h004, v[15:8], r, e);
        xfer(1'b1, lo, v[7:0], r, e);
    endtask : wr16

    // lower byte first loads the latch, then the upper location
    task automatic rd16(input logic [11:0] lo, output logic [15:0] v);
        logic [31:0] r0;
        logic [31:0] r1;
        logic        e;
        xfer(1'b0, lo, 8'h00, r0, e);
        xfer(1'b0, lo + 12'h004, 8'h00, r1, e);
        v = {r1[7:0], r0[7:0]};
    endtask : rd16
endmodule : tcc_cpu_model
`default_nettype wire

//--- test_tcc_timer.sv
`timescale 1ns/1ns
`default_nettype none
module test_tcc_timer
    import tcc_pkg::*;
;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        capture_pin;
    logic        comparator_output;
    logic        external_clock_pin;
    logic        prescale_tick;
    logic        capture_irq_ack;
    logic        overflow_irq_ack;
    logic        capture_irq;
    logic        overflow_irq;
    logic        at_max;
    logic        at_bottom;
    int          errors;
    int          n_compared;
    int          d0;
    int          d1;
    int          n;
    logic [31:0] r;
    logic        e;

    tcc_timer i_tcc_timer (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .capture_pin(capture_pin), .comparator_output(comparator_output),
        .external_clock_pin(external_clock_pin), .prescale_tick(prescale_tick),
        .capture_irq_ack(capture_irq_ack), .overflow_irq_ack(overflow_irq_ack),
        .capture_irq(capture_irq), .overflow_irq(overflow_irq), .at_max(at_max),
        .at_bottom(at_bottom));

    tcc_cpu_model i_tcc_cpu_model (.pclk(pclk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));

    // compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        i_tcc_cpu_model.xfer(1'b1, a, d, r, e);
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        i_tcc_cpu_model.xfer(1'b0, a, 8'h00, r, e);
        check(r, exp);
    endtask : rd

    task automatic rd16c(input logic [11:0] lo, input logic [15:0] exp);
        logic [15:0] v;
        i_tcc_cpu_model.rd16(lo, v);
        check({16'h0000, v}, {16'h0000, exp});
    endtask : rd16c

    // bounded wait: 0 capture irq, 1 overflow irq, 2 at max
    task automatic wait_hi(input int which, output int cnt);
        cnt = 0;
        while (cnt < 80 && !((which == 0 && capture_irq === 1'b1) ||
               (which == 1 && overflow_irq === 1'b1) || (which == 2 && at_max === 1'b1)))
        begin
            @(posedge pclk);
            cnt++;
        end
    endtask : wait_hi

    task automatic stop_test();
        $display("compares %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : stop_test

    // clock, 4 ns period
    initial
    begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    // watchdog
    initial
    begin
        repeat (20000) @(posedge pclk);
        errors++;
        stop_test();
    end

    initial
    begin
        errors = 0;
        n_compared = 0;
        presetn = 1'b0;
        capture_pin = 1'b0;
        comparator_output = 1'b0;
        external_clock_pin = 1'b0;
        prescale_tick = 1'b0;
        capture_irq_ack = 1'b0;
        overflow_irq_ack = 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        check(at_bottom, 1'b1);
        rd(ADDR_CNT_LO, 32'h0);
        i_tcc_cpu_model.xfer(1'b0, 12'h100, 8'h00, r, e);
        check(e, 1'b1);
        check(r, 32'h0);
        $display("test reset and unmapped done");
        // counting on prescale ticks, write priority, stop
        wr(ADDR_CTRL_B, 8'h02);
        i_tcc_cpu_model.wr16(ADDR_CNT_LO, 16'h0100);
        repeat (5)
        begin
            @(posedge pclk);
            prescale_tick <= 1'b1;
            @(posedge pclk);
            prescale_tick <= 1'b0;
        end
        rd16c(ADDR_CNT_LO, 16'h0105);
        check(at_bottom, 1'b0);
        @(posedge pclk);
        prescale_tick <= 1'b1;
        i_tcc_cpu_model.wr16(ADDR_CNT_LO, 16'h2222);
        prescale_tick <= 1'b0;
        rd16c(ADDR_CNT_LO, 16'h2222);
        wr(ADDR_CTRL_B, 8'h00);
        @(posedge pclk);
        prescale_tick <= 1'b1;
        repeat (3) @(posedge pclk);
        prescale_tick <= 1'b0;
        rd16c(ADDR_CNT_LO, 16'h2222);
        $display("test tick count done");
        // external clock, falling then rising edge codes
        for (int c = 6; c < 8; c++)
        begin
            i_tcc_cpu_model.wr16(ADDR_CNT_LO, 16'h0000);
            wr(ADDR_CTRL_B, c[7:0]);
            repeat (3)
            begin
                @(posedge pclk);
                external_clock_pin <= 1'b1;
                repeat (4) @(posedge pclk);
                external_clock_pin <= 1'b0;
                repeat (4) @(posedge pclk);
            end
            repeat (6) @(posedge pclk);
            wr(ADDR_CTRL_B, 8'h00);
            rd16c(ADDR_CNT_LO, 16'h0003);
        end
        $display("test external clock done");
        // wrap at the top sets overflow
        i_tcc_cpu_model.wr16(ADDR_CNT_LO, 16'hfffd);
        wr(ADDR_IRQ_EN, 8'h03);
        wr(ADDR_CTRL_B, 8'h01);
        wait_hi(2, n);
        check(at_max, 1'b1);
        wait_hi(1, n);
        check(overflow_irq, 1'b1);
        wr(ADDR_CTRL_B, 8'h00);
        rd(ADDR_FLAGS, 32'h1);
        @(posedge pclk);
        overflow_irq_ack <= 1'b1;
        @(posedge pclk);
        overflow_irq_ack <= 1'b0;
        repeat (3) @(posedge pclk);
        check(overflow_irq, 1'b0);
        $display("test overflow done");
        // shared latch in a capture-top mode
        wr(ADDR_CTRL_B, 8'h18);
        wr(ADDR_CNT_HI, 8'hab);
        wr(ADDR_CAP_LO, 8'hcd);
        wr(ADDR_CNT_LO, 8'hef);
        rd16c(ADDR_CNT_LO, 16'habef);
        rd16c(ADDR_CAP_LO, 16'habcd);
        wr(ADDR_CNT_LO, 8'h11);
        rd16c(ADDR_CNT_LO, 16'hab11);
        wr(ADDR_CTRL_B, 8'h00);
        i_tcc_cpu_model.wr16(ADDR_CAP_LO, 16'h5566);
        rd16c(ADDR_CAP_LO, 16'habcd);
        $display("test shared latch done");
        // capture on rising, falling, filtered edges
        i_tcc_cpu_model.wr16(ADDR_CNT_LO, 16'ha55a);
        wr(ADDR_FLAGS, 8'h03);
        wr(ADDR_CTRL_B, 8'h40);
        @(posedge pclk);
        capture_pin <= 1'b1;
        wait_hi(0, d0);
        check(capture_irq, 1'b1);
        rd16c(ADDR_CAP_LO, 16'ha55a);
        rd(ADDR_FLAGS, 32'h2);
        wr(ADDR_FLAGS, 8'h02);
        rd(ADDR_FLAGS, 32'h0);
        wr(ADDR_CTRL_B, 8'h00);
        i_tcc_cpu_model.wr16(ADDR_CNT_LO, 16'h1234);
        @(posedge pclk);
        capture_pin <= 1'b0;
        wait_hi(0, n);
        check(capture_irq, 1'b1);
        @(posedge pclk);
        capture_irq_ack <= 1'b1;
        @(posedge pclk);
        capture_irq_ack <= 1'b0;
        repeat (3) @(posedge pclk);
        check(capture_irq, 1'b0);
        rd16c(ADDR_CAP_LO, 16'h1234);
        wr(ADDR_CTRL_B, 8'hc0);
        @(posedge pclk);
        capture_pin <= 1'b1;
        repeat (3) @(posedge pclk);
        capture_pin <= 1'b0;
        repeat (20) @(posedge pclk);
        check(capture_irq, 1'b0);
        capture_pin <= 1'b1;
        wait_hi(0, d1);
        check(32'(d1 - d0), 32'd4);
        $display("test capture done");
        // comparator as source, then capture-top mode shuts the input
        wr(ADDR_CTRL_B, 8'h40);
        wr(ADDR_CMP_CTRL, 8'h01);
        wr(ADDR_FLAGS, 8'h02);
        i_tcc_cpu_model.wr16(ADDR_CNT_LO, 16'h0f0e);
        @(posedge pclk);
        comparator_output <= 1'b1;
        wait_hi(0, n);
        check(capture_irq, 1'b1);
        rd16c(ADDR_CAP_LO, 16'h0f0e);
        wr(ADDR_CTRL_B, 8'h58);
        wr(ADDR_FLAGS, 8'h02);
        @(posedge pclk);
        comparator_output <= 1'b0;
        repeat (4) @(posedge pclk);
        comparator_output <= 1'b1;
        repeat (20) @(posedge pclk);
        check(capture_irq, 1'b0);
        $display("test comparator source done");
        // dual slope on prescale ticks turns at the fixed top
        wr(ADDR_CTRL_A, 8'h01);
        wr(ADDR_CTRL_B, 8'h00);
        i_tcc_cpu_model.wr16(ADDR_CNT_LO, 16'h00fe);
        wr(ADDR_CTRL_B, 8'h02);
        repeat (3)
        begin
            @(posedge pclk);
            prescale_tick <= 1'b1;
            @(posedge pclk);
            prescale_tick <= 1'b0;
        end
        rd16c(ADDR_CNT_LO, 16'h00fd);
        $display("test dual slope done");
        stop_test();
    end
endmodule : test_tcc_timer
`default_nettype wire
